/* File: core/rst_seq_pkg.sv */
package rst_seq_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned REJECT_NS = 5000;
  localparam int unsigned ACCEPT_NS = 9000;
  localparam int unsigned LOAD_MS = 5;
  localparam int unsigned BLANK_MS = 120;
  localparam int unsigned HOST_WAIT_MS = 5;
  localparam int unsigned WAKE_WAIT_MS = 120;
  // least time rounds up
  localparam int unsigned REJECT_CYC = (REJECT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // accept threshold: longest time, rounds down
  localparam int unsigned ACCEPT_CYC = (ACCEPT_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned LOAD_CYC = LOAD_MS * (CLK_HZ / 1000);
  localparam int unsigned BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
  localparam int unsigned HOST_WAIT_CYC = HOST_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_WAIT_CYC = WAKE_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned NVM_WORDS = 8;
  localparam int unsigned NVM_WIDTH = 8;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HELD,
    ST_BLANK,
    ST_LOAD,
    ST_WAIT
  } seq_state_type;
endpackage : rst_seq_pkg

/* File: core/reset_pin_filter.sv */
`timescale 1ns/100ps
`default_nettype none
module reset_pin_filter #(
  parameter int unsigned REJECT = 100,
  parameter int unsigned ACCEPT = 180
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic reset_line_low_i,
  output logic held_o,
  output logic low_seen_o
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic held;
    logic [15:0] width;
  } filt_type;

  filt_type r;
  filt_type next_r;

  initial begin
    if (REJECT == 0 || ACCEPT < REJECT || ACCEPT > 16'hffff) begin
      $error("reset_pin_filter: bad thresholds");
    end
  end

  // ------------------------------------------------------------
  // width counter: level must differ from the held state for the
  // accept width before the held state follows it
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.sync1 = reset_line_low_i;
    next_r.sync2 = r.sync1;
    if ((r.sync2 == 1'b0) != r.held) begin
      // pulse shorter than the reject width never reaches accept
      if (r.width >= 16'(ACCEPT - 1)) begin
        next_r.held = ~r.held;
        next_r.width = 16'h0000;
      end else begin
        next_r.width = r.width + 16'h0001;
      end
    end else begin
      // short high spike inside a valid reset is dropped too
      next_r.width = 16'h0000;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{sync1: 1'b1, sync2: 1'b1, held: 1'b0, width: 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  assign held_o = r.held;
  assign low_seen_o = ~r.sync2;
endmodule : reset_pin_filter
`default_nettype wire

/* File: core/display_hw_reset_sequencer.sv */
// Function
// - host low at least 9us; reject below 5us
// - spikes within valid reset also filtered
// - reload stored settings within 5 ms
// - blanking sequence from active state, 120 ms
// - idle-state reset keeps display blank
// - afterwards all state at reset defaults
// - idle-state release completes within 5 ms
// - active-state release completes within 120 ms
`timescale 1ns/100ps
`default_nettype none
module display_hw_reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned LOAD_CYCLES = LOAD_CYC,
  parameter int unsigned BLANK_CYCLES = BLANK_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_WAIT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic reset_line_low_i,
  input wire logic display_active_i,
  input wire logic [rst_seq_pkg::NVM_WIDTH-1:0] nvm_data_i,
  output logic [$clog2(rst_seq_pkg::NVM_WORDS)-1:0] nvm_addr_o,
  output logic [rst_seq_pkg::NVM_WIDTH-1:0] load_data_o,
  output logic [$clog2(rst_seq_pkg::NVM_WORDS)-1:0] load_addr_o,
  output logic load_we_o,
  output logic display_blank_o,
  output logic defaults_o,
  output logic busy_o,
  output logic cmd_ready_o,
  output logic wake_ready_o
);
  import rst_seq_pkg::*;

  localparam int AW = $clog2(NVM_WORDS);
  // every word costs two cycles: address out, then data in
  localparam int unsigned FETCH_SPAN = 2 * NVM_WORDS;

  typedef struct packed {
    seq_state_type state;
    logic [23:0] count;
    logic [23:0] since;
    logic was_active;
    logic [AW-1:0] addr;
    logic [NVM_WIDTH-1:0] data;
    logic [AW-1:0] waddr;
    logic we;
    logic fetch;
    logic blank;
    logic defaults;
    logic wake;
  } seq_type;

  seq_type r;
  seq_type next_r;
  logic held;
  logic low_seen;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  initial begin
    if (LOAD_CYCLES < FETCH_SPAN + 2) begin
      $error("display_hw_reset_sequencer: load window shorter than the store fetch");
    end
    if (BLANK_CYCLES == 0 || BLANK_CYCLES > 24'hffffff) begin
      $error("display_hw_reset_sequencer: blank count out of range");
    end
    if (WAKE_CYCLES == 0 || WAKE_CYCLES > 24'hffffff) begin
      $error("display_hw_reset_sequencer: wake count out of range");
    end
    // the blank budget is counted from release, so it must cover the load
    if (LOAD_CYCLES > BLANK_CYCLES) begin
      $error("display_hw_reset_sequencer: load must finish inside the blank budget");
    end
  end

  // ------------------------------------------------------------
  // sequence outline
  // ------------------------------------------------------------
  // run   : normal operation, waiting for an accepted low level
  // held  : line accepted low; nothing happens until it is released
  // load  : stored settings copied word by word into the settings
  //         registers, counted from the filtered release
  // blank : only after an active-state reset; stretches the whole
  //         release to the blank budget, still counted from release
  // wait  : one cycle to settle before commands are taken again
  // a new accepted low level in any busy state goes back to held, so a
  // half-finished load is never trusted

  // ------------------------------------------------------------
  // pin filter
  // ------------------------------------------------------------
  reset_pin_filter #(
    .REJECT(REJECT_CYC),
    .ACCEPT(ACCEPT_CYC)
  ) u_filter (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .reset_line_low_i(reset_line_low_i),
    .held_o(held),
    .low_seen_o(low_seen)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.we = 1'b0;
    next_r.fetch = 1'b0;
    if (r.since != 24'hffffff) begin
      next_r.since = r.since + 24'h000001;
    end
    case (r.state)
      ST_RUN: begin
        if (held) begin
          next_r.state = ST_HELD;
          next_r.was_active = display_active_i;
          next_r.blank = 1'b1;
          next_r.defaults = 1'b0;
        end
      end
      ST_HELD: begin
        if (!held) begin
          // count from the filtered release, once the line has been high for the accept width
          next_r.count = 24'h000000;
          next_r.since = 24'h000000;
          next_r.addr = '0;
          next_r.state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_r.count = r.count + 24'h000001;
        // fetch toggles: one cycle to present the address, one to take
        // the word, since the store answers a full cycle after its address
        if (r.count < 24'(FETCH_SPAN)) begin
          next_r.fetch = !r.fetch;
        end
        if (r.fetch) begin
          // address has stood a whole cycle, so the word belongs to it
          next_r.data = nvm_data_i;
          next_r.waddr = r.addr;
          next_r.we = 1'b1;
          if (r.addr != AW'(NVM_WORDS - 1)) begin
            next_r.addr = r.addr + AW'(1);
          end
        end
        if (r.count >= 24'(LOAD_CYCLES - 1)) begin
          next_r.state = r.was_active ? ST_BLANK : ST_WAIT;
          next_r.defaults = 1'b1;
        end
      end
      ST_BLANK: begin
        // blanking runs out inside the active-state budget
        next_r.count = r.count + 24'h000001;
        if (r.count >= 24'(BLANK_CYCLES - 1)) begin
          next_r.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_r.blank = 1'b1;
        next_r.state = ST_RUN;
        next_r.was_active = 1'b0;
      end
      default: next_r.state = ST_RUN;
    endcase
    // a fresh accepted reset goes back to held and drops defaults; was_active is not sampled again
    if (held && r.state != ST_HELD && r.state != ST_RUN) begin
      next_r.state = ST_HELD;
      next_r.defaults = 1'b0;
    end
    // wake gate is timed from release in every state except held
    next_r.wake = !held && r.state != ST_HELD && r.since >= 24'(WAKE_CYCLES - 1);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{state: ST_RUN, count: 24'h000000, since: 24'h000000, was_active: 1'b0,
             addr: '0, data: '0, waddr: '0, we: 1'b0, fetch: 1'b0, blank: 1'b1,
             defaults: 1'b1, wake: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign nvm_addr_o = r.addr;
  assign load_data_o = r.data;
  assign load_addr_o = r.waddr;
  assign load_we_o = r.we;
  assign display_blank_o = r.blank;
  assign defaults_o = r.defaults;
  assign busy_o = r.state != ST_RUN || low_seen;
  // commands accepted only once release processing is over
  assign cmd_ready_o = r.state == ST_RUN && !low_seen;
  assign wake_ready_o = r.wake && cmd_ready_o;
endmodule : display_hw_reset_sequencer
`default_nettype wire

/* File: dv/rst_seq_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rst_seq_chk #(
  parameter int unsigned LOAD_CYCLES = 40,
  parameter int unsigned WAKE_CYCLES = 120
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic reset_line_low_i,
  input wire logic display_active_i,
  input wire logic load_we_o,
  input wire logic display_blank_o,
  input wire logic defaults_o,
  input wire logic busy_o,
  input wire logic cmd_ready_o,
  input wire logic wake_ready_o
);
  // ----
  // pin run lengths, kept through rst_i since the pin is the host's
  // ----
  int lo = 0;
  int hi = 0;
  always @(posedge clock_i) begin
    lo <= reset_line_low_i ? 0 : lo + 1;
    hi <= reset_line_low_i ? hi + 1 : 0;
  end
  // in_seq marks a real reset sequence up to its ready; since_rel counts
  // from the release of the last accepted reset, not from spikes
  logic in_seq = 1'b0;
  int since_rel = 0;
  always @(posedge clock_i) begin
    in_seq <= !defaults_o || (in_seq && !cmd_ready_o);
    since_rel <= defaults_o ? since_rel + 1 : hi;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence released;
    hi == 190;
  endsequence
  a_accept_width: assert property ($fell(defaults_o) |-> lo >= 100)
    else $error("reset taken too early");
  a_spike_free_load: assert property (load_we_o |-> hi >= 100)
    else $error("load while pin low");
  a_we_single: assert property (load_we_o |=> !load_we_o)
    else $error("write strobe too long");
  a_idle_release: assert property (released ##0 !display_active_i |-> ##[0:60] cmd_ready_o)
    else $error("idle release too slow");
  a_active_release: assert property (released |-> ##[0:120] cmd_ready_o)
    else $error("active release too slow");
  a_blank_held: assert property (!defaults_o |-> display_blank_o && busy_o)
    else $error("display shown in reset");
  a_ready_defaults: assert property ($rose(cmd_ready_o) && in_seq |-> defaults_o && hi >= 170 + LOAD_CYCLES)
    else $error("ready too early");
  a_wake_gap: assert property (wake_ready_o |-> since_rel >= WAKE_CYCLES)
    else $error("wake ready too early");
endmodule : rst_seq_chk
bind display_hw_reset_sequencer rst_seq_chk #(
  .LOAD_CYCLES(LOAD_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)
) chk_u (.clock_i, .rst_i, .reset_line_low_i, .display_active_i, .load_we_o,
  .display_blank_o, .defaults_o, .busy_o, .cmd_ready_o, .wake_ready_o);
`default_nettype wire

/* File: dv/reset_host.sv */
`timescale 1ns/100ps
`default_nettype none
module reset_host (
  input wire logic clock_i,
  input wire logic cmd_ready_i,
  input wire logic wake_ready_i,
  output logic reset_line_low_o
);
  initial reset_line_low_o = 1'b1;
  // low run then high run; real resets are held 200 cycles
  task automatic pulse(input int lo, input int hi);
    @(posedge clock_i);
    #1 reset_line_low_o = 1'b0;
    repeat (lo) @(posedge clock_i);
    #1 reset_line_low_o = 1'b1;
    repeat (hi) @(posedge clock_i);
    #1;
  endtask : pulse
  // nothing is sent before the device says so; -1 on timeout
  task automatic wait_ready(input logic wake, output int n);
    n = 0;
    while ((wake ? wake_ready_i : cmd_ready_i) !== 1'b1 && n < 2000) begin
      @(posedge clock_i);
      #1 n++;
    end
    if (n == 2000) n = -1;
  endtask : wait_ready
endmodule : reset_host
`default_nettype wire

/* File: dv/tb_display_hw_reset_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_display_hw_reset_sequencer;
  import rst_seq_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic act = 1'b0;
  logic [7:0] nvm = 8'h00;
  logic [7:0] mem [8];
  logic [7:0] ld;
  logic [2:0] na, la;
  logic pin, we, blank, dflt, cr, wr, bz;
  int failures = 0;
  int checked = 0;
  int seed = 18;
  int nwr, n, m, w;
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) nvm <= #1 mem[na];
  reset_host host_u (.clock_i(clock_i), .cmd_ready_i(cr), .wake_ready_i(wr),
    .reset_line_low_o(pin));
  display_hw_reset_sequencer #(.LOAD_CYCLES(40), .BLANK_CYCLES(60), .WAKE_CYCLES(120)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .reset_line_low_i(pin), .display_active_i(act),
    .nvm_data_i(nvm), .nvm_addr_o(na), .load_data_o(ld), .load_addr_o(la), .load_we_o(we),
    .display_blank_o(blank), .defaults_o(dflt), .busy_o(bz), .cmd_ready_o(cr),
    .wake_ready_o(wr));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // release-to-ready span: filter, then load, or the whole blank budget when active
  function automatic logic [31:0] in_span(int c, logic a);
    int lo;
    lo = 175 + (a ? 60 : 40);
    return 32'(c >= lo && c <= lo + 30);
  endfunction : in_span
  always @(posedge clock_i) begin
    if (we === 1'b1) begin
      nwr++;
      chk("load_data", 32'(mem[la]), 32'(ld));
    end
  end
  initial begin
    for (int i = 0; i < 8; i++) mem[i] = 8'($random(seed));
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    for (int k = 0; k < 6; k++) begin
      w = k == 0 ? 99 : 1 + int'($unsigned($random(seed)) % 90);
      nwr = 0;
      host_u.pulse(w, 200);
      chk("spike_defaults", 1, 32'(dflt));
      chk("spike_writes", 0, nwr);
      chk("spike_busy", 0, 32'(bz));
    end
    for (int r = 0; r < 3; r++) begin
      act = r[0];
      nwr = 0;
      // last pass puts a high glitch inside a held reset
      if (r == 2) host_u.pulse(200, 30);
      host_u.pulse(r == 2 ? 100 : 200, 0);
      host_u.wait_ready(1'b0, n);
      host_u.wait_ready(1'b1, m);
      if (n < 0 || m < 0) begin
        failures++;
        summarize();
      end
      chk("cmd_time", 1, in_span(n, act));
      chk("wake_time", 1, 32'(n + m >= 120));
      chk("writes", 8, nwr);
      chk("defaults", 1, 32'(dflt));
      chk("blank", 1, 32'(blank));
    end
    summarize();
  end
endmodule : tb_display_hw_reset_sequencer
`default_nettype wire
